// ==== hdl/xfer_seq_pkg.sv ====
// Constants, register map, enumerations and carrier structs of the
// state table transfer sequencer.
// Assumes one 25 MHz clock and word addressed registers.
package xfer_seq_pkg;

  // ********************************************************************
  // Bus and widths
  // ********************************************************************
  localparam int REG_AW = 5;
  localparam int REG_DW = 32;
  localparam int CNT_W = 17;
  localparam int DATA_W = 16;
  localparam int NUM_TYPES = 4;

  // ********************************************************************
  // Register indexes
  // ********************************************************************
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_BASE0 = 5'h01;
  localparam logic [4:0] REG_EXT0 = 5'h05;
  localparam logic [4:0] REG_SCANS = 5'h09;
  localparam logic [4:0] REG_NT_START = 5'h0a;
  localparam logic [4:0] REG_NT_LEN = 5'h0b;
  localparam logic [4:0] REG_TOT0 = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_SLICE = 5'h11;
  localparam logic [4:0] REG_SCAN_CNT = 5'h12;
  localparam logic [4:0] REG_TYPE_MASK = 5'h1c;

  // ********************************************************************
  // Reference types and counts
  // ********************************************************************
  localparam logic [1:0] T_COIL = 2'h0;
  localparam logic [1:0] T_DISC = 2'h1;
  localparam logic [1:0] T_INREG = 2'h2;
  localparam logic [1:0] T_HOLD = 2'h3;
  localparam logic [3:0] BLK_MASK = 4'hf;
  localparam logic [16:0] BLK_ROUND = 17'h0000f;
  localparam int BLK_SHIFT = 4;
  localparam logic [16:0] MIN_HOLD = 17'h00010;
  localparam logic [16:0] DEF_COIL = 17'h02000;
  localparam logic [16:0] DEF_DISC = 17'h02000;
  localparam logic [16:0] DEF_INREG = 17'h00400;
  localparam logic [16:0] DEF_HOLD = 17'h02400;
  localparam logic [16:0] MAX_TAB_V0 = 17'h02800;
  localparam logic [16:0] MAX_TAB_V1 = 17'h08000;
  localparam logic [16:0] MAX_TAB_V2 = 17'h10000;
  // Storage bits of one transferred word: 16 points x 3 bit, 16, 16 + 2
  localparam logic [31:0] BITS_COIL_WORD = 32'h30;
  localparam logic [31:0] BITS_DISC_WORD = 32'h30;
  localparam logic [31:0] BITS_INREG = 32'h10;
  localparam logic [31:0] BITS_HOLD = 32'h12;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_NS = 40;
  localparam int BITS_PER_BYTE = 8;
  localparam int COST_NS_V0 = 1600000;
  localparam int COST_NS_V1 = 2000000;
  localparam int COST_NS_V2 = 1900000;
  localparam int CYC_PER_BIT_V0 =
    (COST_NS_V0 + BITS_PER_BYTE * CLK_NS - 1) / (BITS_PER_BYTE * CLK_NS);
  localparam int CYC_PER_BIT_V1 =
    (COST_NS_V1 + BITS_PER_BYTE * CLK_NS - 1) / (BITS_PER_BYTE * CLK_NS);
  localparam int CYC_PER_BIT_V2 =
    (COST_NS_V2 + BITS_PER_BYTE * CLK_NS - 1) / (BITS_PER_BYTE * CLK_NS);
  localparam int KICK_NS = 40000;
  localparam logic [15:0] KICK_CYC = 16'(KICK_NS / CLK_NS);

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    MODE_DEFAULT = 2'b00,
    MODE_FIXED = 2'b01,
    MODE_EXTRA = 2'b10,
    MODE_ALL = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_NEXT = 3'b010,
    S_REQ = 3'b011,
    S_COST = 3'b100,
    S_SEND_RD = 3'b101,
    S_SEND_OUT = 3'b110,
    S_DONE = 3'b111
  } seq_state_t;

  typedef struct packed {
    logic [1:0] ref_type;
    logic [16:0] index;
  } fetch_req_t;

  typedef struct packed {
    logic last;
    logic [1:0] ref_type;
    logic [15:0] data;
  } link_word_t;

endpackage

// ==== hdl/xfer_buf_mem.sv ====
// Simple dual port word store holding one scan's fetched words.
// Assumes one clock; read data appear registered one cycle after re.
`timescale 1ns/1ps
`default_nettype none
module xfer_buf_mem #(
  parameter int AW = 16,
  parameter int W = 18
) (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  // ********************************************************************
  // Write and registered read
  // ********************************************************************
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

// ==== hdl/state_table_transfer_sequencer.sv ====
// State table transfer sequencer of the redundancy link module.
// Assumes the controller answers each fetch request with rsp_valid,
// and the peer link accepts words with link_ready.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Peer copy overlaps logic; scan extended only while copy outlasts logic.
// - Storage cost: 3 bit per point, 2 bytes, 2 bytes plus 2 bit.
// - Fetch lengthens scan by 1.6, 2.0 or 1.9 ms per byte.
// - Long transfers keep the watchdog kicked, never timing out.
// - Order: coils, discrete inputs, input registers, holding registers.
// - Holding words inside the non-transfer region are skipped.
// - Default sends first 8192 coils and 8192 discrete inputs.
// - Default sends 1K input and 9K holding registers.
// - Default holding count rounded up to 16 unless all included.
// - Modes: fixed counts, fixed plus extra, or everything configured.
// - Area from 16 holding up to 10K, 32K or 64K table.
// - Each type starts at its lowest reference, contiguous to count.
// - Extra region follows the per-scan region, multiples of 16.
// - Extra region sliced over scans, successive slices, wrapping.
// - Extra data walks coils, discrete, input, holding in order.
// - Controller hands data at scan start, then resumes logic.
// - Each transfer starts by requesting data from the controller.
// - Data forwarded to peer module while logic runs.
module state_table_transfer_sequencer #(
  parameter int MEM_AW = 16,
  parameter int unsigned COST_CYC_V0 = xfer_seq_pkg::CYC_PER_BIT_V0,
  parameter int unsigned COST_CYC_V1 = xfer_seq_pkg::CYC_PER_BIT_V1,
  parameter int unsigned COST_CYC_V2 = xfer_seq_pkg::CYC_PER_BIT_V2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic scan_start,
  input wire logic logic_done,
  output logic ctrl_hold,
  output logic scan_extend,
  output logic req_valid,
  output xfer_seq_pkg::fetch_req_t req,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output logic link_valid,
  input wire logic link_ready,
  output xfer_seq_pkg::link_word_t link,
  output logic scan_done,
  output logic wdog_kick
);

  if (MEM_AW < 4 || MEM_AW > 17 || COST_CYC_V0 < 1 || COST_CYC_V1 < 1 ||
      COST_CYC_V2 < 1) begin : g_bad_param
    $error("Unsupported sequencer parameters");
  end

  typedef struct packed {
    xfer_seq_pkg::mode_t mode;
    logic [1:0] variant;
    logic [3:0][16:0] base;
    logic [3:0][16:0] ext;
    logic [3:0][16:0] tot;
    logic [7:0] scans;
    logic [16:0] nt_start;
    logic [16:0] nt_len;
    xfer_seq_pkg::seq_state_t fsm;
    logic [1:0] t;
    logic seg;
    logic [16:0] idx;
    logic [16:0] seg_end;
    logic [3:0][16:0] base_w;
    logic [3:0][16:0] ext_w;
    logic [3:0][16:0] slice_w;
    logic [3:0][16:0] ext_off;
    logic [MEM_AW:0] wr_ptr;
    logic [MEM_AW:0] rd_ptr;
    logic last;
    logic [31:0] cost_cnt;
    logic [15:0] kick_cnt;
    logic kick;
    logic [7:0] slice_k;
    logic [15:0] scan_cnt;
    logic done;
    logic cfg_err;
    xfer_seq_pkg::mode_t mode_used;
    logic [31:0] rdata;
  } st_t;

  st_t s_r;
  st_t s_nxt;
  logic mem_we;
  logic mem_re;
  logic [MEM_AW-1:0] mem_waddr;
  logic [17:0] mem_wdata;
  logic [MEM_AW-1:0] mem_raddr;
  logic [17:0] mem_q;

  xfer_buf_mem #(
    .AW(MEM_AW),
    .W(18)
  ) u_buf (
    .ref_clk(ref_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .re(mem_re),
    .raddr(mem_raddr),
    .rdata(mem_q)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    logic cfg_bad;
    xfer_seq_pkg::mode_t use_mode;
    logic [16:0] max_tab;
    logic [16:0] refs;
    logic [16:0] erefs;
    logic [16:0] ew;
    logic [7:0] sc;
    logic [16:0] rem;
    logic [16:0] len;
    logic [16:0] start;
    logic [31:0] cost_bit;
    logic [31:0] unit_bits;
    logic in_nt;
    logic [16:0] off_nxt;
    cfg_bad = 1'b0;
    use_mode = s_r.mode;
    max_tab = xfer_seq_pkg::MAX_TAB_V2;
    refs = '0;
    erefs = '0;
    ew = '0;
    sc = (s_r.scans == 8'h00) ? 8'h01 : s_r.scans;
    rem = '0;
    len = '0;
    start = '0;
    cost_bit = 32'(COST_CYC_V2);
    unit_bits = xfer_seq_pkg::BITS_HOLD;
    in_nt = 1'b0;
    off_nxt = '0;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.kick = 1'b0;
    s_nxt.rdata = '0;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_waddr = s_r.wr_ptr[MEM_AW-1:0];
    mem_wdata = {s_r.t, rsp_data};
    mem_raddr = s_r.rd_ptr[MEM_AW-1:0];

    for (int i = 0; i < xfer_seq_pkg::NUM_TYPES; i++) begin
      if (s_r.base[i][3:0] != 4'h0 || s_r.ext[i][3:0] != 4'h0) begin
        cfg_bad = 1'b1;
      end
    end
    if (s_r.base[xfer_seq_pkg::T_HOLD] < xfer_seq_pkg::MIN_HOLD) begin
      cfg_bad = 1'b1;
    end
    if ((s_r.mode == xfer_seq_pkg::MODE_FIXED ||
         s_r.mode == xfer_seq_pkg::MODE_EXTRA) && cfg_bad) begin
      use_mode = xfer_seq_pkg::MODE_DEFAULT;
    end
    case (s_r.variant)
      2'h0: max_tab = xfer_seq_pkg::MAX_TAB_V0;
      2'h1: max_tab = xfer_seq_pkg::MAX_TAB_V1;
      default: max_tab = xfer_seq_pkg::MAX_TAB_V2;
    endcase
    case (s_r.variant)
      2'h0: cost_bit = 32'(COST_CYC_V0);
      2'h1: cost_bit = 32'(COST_CYC_V1);
      default: cost_bit = 32'(COST_CYC_V2);
    endcase
    case (s_r.t)
      xfer_seq_pkg::T_COIL: unit_bits = xfer_seq_pkg::BITS_COIL_WORD;
      xfer_seq_pkg::T_DISC: unit_bits = xfer_seq_pkg::BITS_DISC_WORD;
      xfer_seq_pkg::T_INREG: unit_bits = xfer_seq_pkg::BITS_INREG;
      default: unit_bits = xfer_seq_pkg::BITS_HOLD;
    endcase
    in_nt = (s_r.t == xfer_seq_pkg::T_HOLD) && (s_r.nt_len != '0) &&
      (s_r.idx >= s_r.nt_start) &&
      ({1'b0, s_r.idx} < ({1'b0, s_r.nt_start} + {1'b0, s_r.nt_len}));

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        xfer_seq_pkg::REG_CTRL: begin
          s_nxt.mode = xfer_seq_pkg::mode_t'(reg_wdata[1:0]);
          s_nxt.variant = reg_wdata[3:2];
        end
        xfer_seq_pkg::REG_SCANS: s_nxt.scans = reg_wdata[7:0];
        xfer_seq_pkg::REG_NT_START: s_nxt.nt_start = reg_wdata[16:0];
        xfer_seq_pkg::REG_NT_LEN: s_nxt.nt_len = reg_wdata[16:0];
        default: begin
          if (reg_addr < xfer_seq_pkg::REG_EXT0 &&
              reg_addr >= xfer_seq_pkg::REG_BASE0) begin
            s_nxt.base[reg_addr[1:0] - 2'h1] = reg_wdata[16:0];
          end else if (reg_addr < xfer_seq_pkg::REG_SCANS &&
                       reg_addr >= xfer_seq_pkg::REG_EXT0) begin
            s_nxt.ext[reg_addr[1:0] - 2'h1] = reg_wdata[16:0];
          end else if (reg_addr < xfer_seq_pkg::REG_STATUS &&
                       reg_addr >= xfer_seq_pkg::REG_TOT0) begin
            s_nxt.tot[reg_addr[1:0]] = reg_wdata[16:0];
          end
        end
      endcase
    end
    // Register reads
    if (reg_rd) begin
      case (reg_addr)
        xfer_seq_pkg::REG_CTRL: s_nxt.rdata = {28'h0, s_r.variant, s_r.mode};
        xfer_seq_pkg::REG_SCANS: s_nxt.rdata = {24'h0, s_r.scans};
        xfer_seq_pkg::REG_NT_START: s_nxt.rdata = {15'h0, s_r.nt_start};
        xfer_seq_pkg::REG_NT_LEN: s_nxt.rdata = {15'h0, s_r.nt_len};
        xfer_seq_pkg::REG_STATUS: begin
          s_nxt.rdata = {26'h0, s_r.mode_used, ctrl_hold, s_r.cfg_err,
            1'b0, (s_r.fsm != xfer_seq_pkg::S_IDLE)};
        end
        xfer_seq_pkg::REG_SLICE: s_nxt.rdata = {24'h0, s_r.slice_k};
        xfer_seq_pkg::REG_SCAN_CNT: s_nxt.rdata = {16'h0, s_r.scan_cnt};
        default: begin
          if (reg_addr < xfer_seq_pkg::REG_EXT0 &&
              reg_addr >= xfer_seq_pkg::REG_BASE0) begin
            s_nxt.rdata = {15'h0, s_r.base[reg_addr[1:0] - 2'h1]};
          end else if (reg_addr < xfer_seq_pkg::REG_SCANS &&
                       reg_addr >= xfer_seq_pkg::REG_EXT0) begin
            s_nxt.rdata = {15'h0, s_r.ext[reg_addr[1:0] - 2'h1]};
          end else if (reg_addr < xfer_seq_pkg::REG_STATUS &&
                       reg_addr >= xfer_seq_pkg::REG_TOT0) begin
            s_nxt.rdata = {15'h0, s_r.tot[reg_addr[1:0]]};
          end
        end
      endcase
    end

    if (s_r.fsm != xfer_seq_pkg::S_IDLE) begin
      if (s_r.kick_cnt >= xfer_seq_pkg::KICK_CYC - 16'h0001) begin
        s_nxt.kick_cnt = '0;
        s_nxt.kick = 1'b1;
      end else begin
        s_nxt.kick_cnt = s_r.kick_cnt + 16'h0001;
      end
    end else begin
      s_nxt.kick_cnt = '0;
    end

    case (s_r.fsm)
      xfer_seq_pkg::S_IDLE: begin
        if (scan_start) begin
          s_nxt.mode_used = use_mode;
          s_nxt.cfg_err = cfg_bad && (use_mode != s_r.mode);
          for (int i = 0; i < xfer_seq_pkg::NUM_TYPES; i++) begin
            erefs = '0;
            case (use_mode)
              xfer_seq_pkg::MODE_FIXED: refs = s_r.base[i];
              xfer_seq_pkg::MODE_EXTRA: begin
                refs = s_r.base[i];
                erefs = s_r.ext[i];
              end
              xfer_seq_pkg::MODE_ALL: refs = s_r.tot[i];
              default: begin
                if (i == 0) begin
                  refs = xfer_seq_pkg::DEF_COIL;
                end else if (i == 1) begin
                  refs = xfer_seq_pkg::DEF_DISC;
                end else if (i == 2) begin
                  refs = xfer_seq_pkg::DEF_INREG;
                end else begin
                  refs = (xfer_seq_pkg::DEF_HOLD + xfer_seq_pkg::BLK_ROUND) &
                    ~xfer_seq_pkg::BLK_ROUND;
                end
                if (s_r.tot[i] < refs) begin
                  refs = s_r.tot[i];
                end
              end
            endcase
            if (refs > max_tab) begin
              refs = max_tab;
            end
            if (erefs > max_tab) begin
              erefs = max_tab;
            end
            if (i < 2) begin
              refs = 17'((18'(refs) + 18'(xfer_seq_pkg::BLK_ROUND)) >>
                xfer_seq_pkg::BLK_SHIFT);
              erefs = 17'(erefs >> xfer_seq_pkg::BLK_SHIFT);
            end
            s_nxt.base_w[i] = refs;
            s_nxt.ext_w[i] = erefs;
            s_nxt.slice_w[i] = 17'((18'(erefs) + 18'(sc) - 18'h1) / 18'(sc));
            if (s_r.ext_off[i] >= erefs) begin
              s_nxt.ext_off[i] = '0;
            end
          end
          s_nxt.t = xfer_seq_pkg::T_COIL;
          s_nxt.seg = 1'b0;
          s_nxt.wr_ptr = '0;
          s_nxt.rd_ptr = '0;
          s_nxt.fsm = xfer_seq_pkg::S_SETUP;
        end
      end
      xfer_seq_pkg::S_SETUP: begin
        if (!s_r.seg) begin
          start = '0;
          len = s_r.base_w[s_r.t];
        end else begin
          start = 17'(s_r.base_w[s_r.t] + s_r.ext_off[s_r.t]);
          rem = 17'(s_r.ext_w[s_r.t] - s_r.ext_off[s_r.t]);
          len = (s_r.slice_w[s_r.t] < rem) ? s_r.slice_w[s_r.t] : rem;
        end
        s_nxt.idx = start;
        s_nxt.seg_end = 17'(start + len);
        s_nxt.fsm = (len == '0) ? xfer_seq_pkg::S_NEXT : xfer_seq_pkg::S_REQ;
      end
      xfer_seq_pkg::S_NEXT: begin
        if (!s_r.seg) begin
          s_nxt.seg = 1'b1;
          s_nxt.fsm = xfer_seq_pkg::S_SETUP;
        end else begin
          s_nxt.seg = 1'b0;
          if (s_r.t == xfer_seq_pkg::T_HOLD) begin
            s_nxt.fsm = (s_r.wr_ptr == '0) ? xfer_seq_pkg::S_DONE :
              xfer_seq_pkg::S_SEND_RD;
          end else begin
            s_nxt.t = s_r.t + 2'h1;
            s_nxt.fsm = xfer_seq_pkg::S_SETUP;
          end
        end
      end
      xfer_seq_pkg::S_REQ: begin
        if (in_nt || s_r.wr_ptr[MEM_AW]) begin
          s_nxt.idx = s_r.idx + 17'h00001;
          s_nxt.fsm = (s_r.idx + 17'h00001 == s_r.seg_end) ?
            xfer_seq_pkg::S_NEXT : xfer_seq_pkg::S_REQ;
        end else if (rsp_valid) begin
          mem_we = 1'b1;
          s_nxt.wr_ptr = s_r.wr_ptr + (MEM_AW+1)'(1);
          s_nxt.cost_cnt = 32'(unit_bits * cost_bit);
          s_nxt.fsm = xfer_seq_pkg::S_COST;
        end
      end
      xfer_seq_pkg::S_COST: begin
        if (s_r.cost_cnt <= 32'h1) begin
          s_nxt.idx = s_r.idx + 17'h00001;
          s_nxt.fsm = (s_r.idx + 17'h00001 == s_r.seg_end) ?
            xfer_seq_pkg::S_NEXT : xfer_seq_pkg::S_REQ;
        end else begin
          s_nxt.cost_cnt = s_r.cost_cnt - 32'h1;
        end
      end
      xfer_seq_pkg::S_SEND_RD: begin
        mem_re = 1'b1;
        s_nxt.last = (s_r.rd_ptr + (MEM_AW+1)'(1) == s_r.wr_ptr);
        s_nxt.fsm = xfer_seq_pkg::S_SEND_OUT;
      end
      xfer_seq_pkg::S_SEND_OUT: begin
        if (link_ready) begin
          s_nxt.rd_ptr = s_r.rd_ptr + (MEM_AW+1)'(1);
          s_nxt.fsm = s_r.last ? xfer_seq_pkg::S_DONE :
            xfer_seq_pkg::S_SEND_RD;
        end
      end
      xfer_seq_pkg::S_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.scan_cnt = s_r.scan_cnt + 16'h0001;
        for (int i = 0; i < xfer_seq_pkg::NUM_TYPES; i++) begin
          off_nxt = 17'(s_r.ext_off[i] + s_r.slice_w[i]);
          s_nxt.ext_off[i] = (off_nxt >= s_r.ext_w[i]) ? '0 : off_nxt;
        end
        s_nxt.slice_k = (s_r.slice_k + 8'h01 >= sc) ? 8'h00 :
          s_r.slice_k + 8'h01;
        s_nxt.fsm = xfer_seq_pkg::S_IDLE;
      end
      default: s_nxt.fsm = xfer_seq_pkg::S_IDLE;
    endcase

    if (rst) begin
      s_nxt = '0;
      s_nxt.scans = 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_r <= s_nxt;
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // hold logic during hand-off
  assign ctrl_hold = (s_r.fsm == xfer_seq_pkg::S_SETUP) ||
    (s_r.fsm == xfer_seq_pkg::S_NEXT) || (s_r.fsm == xfer_seq_pkg::S_REQ) ||
    (s_r.fsm == xfer_seq_pkg::S_COST);
  // extend only if copy outlasts logic
  assign scan_extend = logic_done && (s_r.fsm != xfer_seq_pkg::S_IDLE) &&
    !ctrl_hold;
  assign req_valid = (s_r.fsm == xfer_seq_pkg::S_REQ) &&
    !(s_r.t == xfer_seq_pkg::T_HOLD && s_r.nt_len != '0 &&
      s_r.idx >= s_r.nt_start &&
      ({1'b0, s_r.idx} < ({1'b0, s_r.nt_start} + {1'b0, s_r.nt_len}))) &&
    !s_r.wr_ptr[MEM_AW];
  assign req.ref_type = s_r.t;
  assign req.index = s_r.idx;
  assign link_valid = (s_r.fsm == xfer_seq_pkg::S_SEND_OUT);
  assign link.last = s_r.last;
  assign link.ref_type = mem_q[17:16];
  assign link.data = mem_q[15:0];
  assign reg_rdata = s_r.rdata;
  assign scan_done = s_r.done;
  assign wdog_kick = s_r.kick;

endmodule
`default_nettype wire

// ==== test/xfer_seq_props.sv ====
// Port checker of the transfer sequencer.
// Assumes binding to the sequencer top module.
`timescale 1ns/1ps
`default_nettype none
module xfer_seq_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic logic_done,
  input wire logic ctrl_hold,
  input wire logic scan_extend,
  input wire logic req_valid,
  input wire xfer_seq_pkg::fetch_req_t req,
  input wire logic rsp_valid,
  input wire logic link_valid,
  input wire logic link_ready,
  input wire xfer_seq_pkg::link_word_t link,
  input wire logic scan_done,
  input wire logic wdog_kick
);
  // ******
  // Assertions
  // ******
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence last_acc;
    link_valid && link_ready && link.last;
  endsequence
  sequence done_pulse;
    scan_done ##1 !scan_done;
  endsequence
  req_hold_a: assert property (
    req_valid && !rsp_valid |=> req_valid && $stable(req))
    else $error("fetch request changed early");
  fetch_held_a: assert property (
    req_valid |-> ctrl_hold) else $error("fetch while logic runs");
  scan_ext_a: assert property (
    scan_extend |-> logic_done && !ctrl_hold)
    else $error("scan extended wrongly");
  ext_busy_a: assert property (
    logic_done && link_valid |-> scan_extend)
    else $error("copy outlasting logic not extended");
  fetch_cost_a: assert property (
    req_valid && rsp_valid |=> !req_valid [*8])
    else $error("fetch cost gap too short");
  done_after_a: assert property (
    last_acc |-> ##[1:3] scan_done) else $error("no scan done");
  done_once_a: assert property (
    scan_done |-> done_pulse) else $error("scan done too long");
  kick_pulse_a: assert property (
    wdog_kick |=> !wdog_kick) else $error("kick too long");
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h0) else $error("stray read data");
endmodule
bind state_table_transfer_sequencer xfer_seq_props u_props (.ref_clk,
  .rst, .reg_rd, .reg_rdata, .logic_done, .ctrl_hold, .scan_extend,
  .req_valid, .req, .rsp_valid, .link_valid, .link_ready, .link,
  .scan_done, .wdog_kick);
`default_nettype wire

// ==== test/ctrl_model.sv ====
// Controller model answering fetch requests, fast and slow in turn.
// Assumes one clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire xfer_seq_pkg::fetch_req_t req,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  // ******
  // Answer path
  // ******
  logic [1:0] wait_r;
  logic slow_r;
  always_ff @(posedge ref_clk) begin
    rsp_valid <= 1'b0;
    rsp_data <= rst ? 16'h5a5a : ~rsp_data;
    if (rst) begin
      wait_r <= 2'h0;
      slow_r <= 1'b0;
    end else if (req_valid && !rsp_valid) begin
      if (wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else begin
        rsp_valid <= 1'b1;
        rsp_data <= {req.ref_type, req.index[13:0]};
        wait_r <= slow_r ? 2'h0 : 2'h3;
        slow_r <= ~slow_r;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/state_table_transfer_sequencer_tb.sv ====
// Self-checking bench of the transfer sequencer.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module state_table_transfer_sequencer_tb;
  // ******
  // Signals and instances
  // ******
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic scan_start = 1'b0;
  logic logic_done = 1'b0;
  logic link_ready = 1'b0;
  logic [31:0] reg_rdata, v;
  logic ctrl_hold, scan_extend, req_valid, rsp_valid, link_valid;
  logic scan_done, wdog_kick;
  logic [15:0] rsp_data;
  xfer_seq_pkg::fetch_req_t req;
  xfer_seq_pkg::link_word_t link;
  xfer_seq_pkg::link_word_t q[$];
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  always #20 ref_clk = ~ref_clk;
  state_table_transfer_sequencer #(.MEM_AW(8), .COST_CYC_V0(1),
    .COST_CYC_V1(1), .COST_CYC_V2(1)) uut (.ref_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scan_start, .logic_done,
    .ctrl_hold, .scan_extend, .req_valid, .req, .rsp_valid, .rsp_data,
    .link_valid, .link_ready, .link, .scan_done, .wdog_kick);
  ctrl_model cm (.ref_clk, .rst, .req_valid, .req, .rsp_valid, .rsp_data);
  // ******
  // Peer side, timeout and tasks
  // ******
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    link_ready <= (cyc % 3) != 0;
    if (!rst && link_valid === 1'b1 && link_ready) q.push_back(link);
    if (cyc == 80000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
  task automatic set4(input logic [4:0] b, input logic [31:0] d0, d1, d2,
                      d3);
    wr(b, d0);
    wr(b + 5'h1, d1);
    wr(b + 5'h2, d2);
    wr(b + 5'h3, d3);
  endtask
  task automatic run_scan(input int e[4]);
    int n, t, x, g, gm;
    int c[4];
    bit go;
    q.delete();
    c = '{0, 0, 0, 0};
    n = 0;
    t = 0;
    x = 0;
    g = 0;
    gm = 0;
    go = 1'b0;
    @(posedge ref_clk);
    scan_start <= 1'b1;
    @(posedge ref_clk);
    scan_start <= 1'b0;
    while (scan_done !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      if (go) logic_done <= 1'b1;
      @(negedge ref_clk);
      go = ctrl_hold === 1'b0 && n > 2;
      if (scan_extend === 1'b1) x++;
      g = (wdog_kick === 1'b1) ? 0 : g + 1;
      if (g > gm) gm = g;
      n++;
    end
    @(posedge ref_clk);
    logic_done <= 1'b0;
    chk("scan done", n < 20000, 1);
    chk("scan extend", x > 0, 1);
    chk("kick gap", gm <= xfer_seq_pkg::KICK_CYC, 1);
    foreach (q[i]) begin
      chk("type order", q[i].ref_type < t, 0);
      t = q[i].ref_type;
      c[t]++;
    end
    chk("last flag", q[q.size() - 1].last, 1);
    foreach (e[k]) chk("type words", c[k], e[k]);
  endtask
  // ******
  // Scenarios
  // ******
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(xfer_seq_pkg::REG_SCANS);
    chk("scans reset", v, 32'h1);
    wr(5'h18, 32'h5);
    rd(5'h18);
    chk("unmapped", v, 32'h0);
    set4(xfer_seq_pkg::REG_TOT0, 64, 64, 64, 64);
    wr(xfer_seq_pkg::REG_CTRL, 32'h9);
    set4(xfer_seq_pkg::REG_BASE0, 16, 16, 16, 32);
    wr(xfer_seq_pkg::REG_NT_START, 32'h4);
    wr(xfer_seq_pkg::REG_NT_LEN, 32'h2);
    run_scan('{1, 1, 16, 30});
    chk("input reg", q[2].data, 16'h8000);
    chk("past hole", q[22].data, 16'hc006);
    wr(xfer_seq_pkg::REG_NT_LEN, 32'h0);
    wr(xfer_seq_pkg::REG_BASE0, 32'h11);
    run_scan('{4, 4, 64, 64});
    rd(xfer_seq_pkg::REG_STATUS);
    chk("cfg error", v[5:2], 4'h1);
    wr(xfer_seq_pkg::REG_CTRL, 32'h0);
    set4(xfer_seq_pkg::REG_TOT0, 32, 32, 16, 24);
    run_scan('{2, 2, 16, 24});
    wr(xfer_seq_pkg::REG_CTRL, 32'h2);
    set4(xfer_seq_pkg::REG_TOT0, 64, 64, 64, 64);
    set4(xfer_seq_pkg::REG_BASE0, 16, 0, 0, 16);
    set4(xfer_seq_pkg::REG_EXT0, 32, 0, 0, 0);
    wr(xfer_seq_pkg::REG_SCANS, 32'h2);
    for (int s = 0; s < 3; s++) begin
      run_scan('{2, 0, 0, 16});
      chk("extra slice", q[1].data, 1 + s % 2);
    end
    wr(xfer_seq_pkg::REG_CTRL, 32'h3);
    set4(xfer_seq_pkg::REG_TOT0, 32, 16, 16, 16);
    run_scan('{2, 1, 16, 16});
    end_of_test();
  end
endmodule
`default_nettype wire
